// *** rtl/attr_rate_monitor.sv ***
// Error-rate judge and failure history for one monitored attribute.
// Assumes one-cycle op and error strobes on ref_clk.
`timescale 1ns/1ps
module attr_rate_monitor #(
  parameter int unsigned INTERVAL_LEN = 1000,
  parameter int unsigned ERR_THRESH = 20,
  parameter int unsigned PRED_THRESH = 8,
  parameter int unsigned CW = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic op_evt,
  input wire logic err_evt,
  output logic pred_fail,
  output logic [7:0] history
);
  logic [CW-1:0] op_cnt_r;
  logic [CW-1:0] err_cnt_r;
  logic [7:0] hist_r;
  logic [CW-1:0] op_nxt;
  logic [CW-1:0] err_nxt;
  logic bad;
  logic full;

  function automatic logic [CW-1:0] bump(input logic [CW-1:0] v, input logic en);
    bump = en ? v + CW'(1) : v;
  endfunction : bump

  assign op_nxt = bump(op_cnt_r, op_evt);
  assign err_nxt = bump(err_cnt_r, err_evt);
  assign bad = err_nxt > CW'(ERR_THRESH);
  assign full = op_nxt >= CW'(INTERVAL_LEN);

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable) begin
      op_cnt_r <= '0;
      err_cnt_r <= '0;
    end else if (bad || full) begin
      op_cnt_r <= '0;
      err_cnt_r <= '0;
    end else begin
      op_cnt_r <= op_nxt;
      err_cnt_r <= err_nxt;
    end
  end

  // History saturates at both ends
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !enable) begin
      hist_r <= '0;
    end else if (bad && hist_r != 8'hFF) begin
      hist_r <= hist_r + 8'h01;
    end else if (!bad && full && hist_r != 8'h00) begin
      hist_r <= hist_r - 8'h01;
    end
  end

  assign history = hist_r;
  assign pred_fail = hist_r >= 8'(PRED_THRESH);
endmodule : attr_rate_monitor

// *** rtl/drive_health_monitor.sv ***
// Drive health monitor: rate judging, hourly offline pass, thermal watch,
// self-test sequencing and sense reporting behind an Avalon-MM slave.
// Assumes media engines answer with done strobes on the same clock.
`timescale 1ns/1ps
module drive_health_monitor #(
  parameter int unsigned SEC_CYC = drive_health_pkg::SEC_CYC,
  parameter int unsigned DELAY_CYC = drive_health_pkg::DELAY_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [drive_health_pkg::ATTR_N-1:0] attr_op,
  input wire logic [drive_health_pkg::ATTR_N-1:0] attr_err,
  input wire logic host_busy,
  output logic host_hold,
  output logic meas_req,
  output logic meas_abort,
  input wire logic meas_done,
  output logic save_req,
  input wire logic save_done,
  output logic temp_sample,
  input wire logic temp_valid,
  input wire logic [7:0] temp_primary,
  input wire logic [7:0] temp_reference,
  input wire logic motor_spin_fail,
  input wire logic motor_speed_fail,
  input wire logic servo_lock_fail,
  input wire logic config_read_fail,
  output logic not_ready,
  output logic dst_start,
  output logic dst_stop,
  output logic dst_scan_all,
  output logic retry_force,
  input wire logic dst_done,
  input wire logic seek_err_final,
  input wire logic track_err_final,
  input wire logic read_err_final,
  input wire logic write_err_final,
  output logic exc_pending,
  output drive_health_pkg::sense_t exc_sense
);
  localparam int unsigned N = drive_health_pkg::ATTR_N;

  typedef enum logic [1:0] {OFF_IDLE, OFF_MEAS, OFF_SAVE, OFF_ABORT} off_state_t;
  typedef enum logic {DST_IDLE, DST_RUN} dst_state_t;

  // Bus slave: one wait cycle, then the answer
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_mux;
  logic wr_go;
  logic sel_ctrl;
  logic sel_cmd;
  logic sel_limit;
  logic sel_time;
  logic sel_temp;
  logic sel_exc;
  logic sel_diag;
  logic sel_stat;

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go = avs_write && ack_r;
  assign sel_ctrl = avs_address == drive_health_pkg::OFF_CTRL;
  assign sel_cmd = avs_address == drive_health_pkg::OFF_CMD;
  assign sel_limit = avs_address == drive_health_pkg::OFF_LIMIT;
  assign sel_time = avs_address == drive_health_pkg::OFF_TIME;
  assign sel_temp = avs_address == drive_health_pkg::OFF_TEMP;
  assign sel_exc = avs_address == drive_health_pkg::OFF_EXC;
  assign sel_diag = avs_address == drive_health_pkg::OFF_DIAG;
  assign sel_stat = avs_address == drive_health_pkg::OFF_STAT;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r) begin
        rdata_r <= rdata_mux;
      end
    end
  end
  assign avs_readdata = rdata_r;

  // Control and limit registers
  drive_health_pkg::ctrl_t ctrl_r;
  logic [7:0] limit_r;
  logic online_en;
  logic offline_en;
  logic report_on;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= drive_health_pkg::CTRL_RST;
      limit_r <= drive_health_pkg::LIMIT_RST;
    end else if (wr_go) begin
      if (sel_ctrl) begin
        ctrl_r <= avs_writedata[6:0];
      end
      if (sel_limit) begin
        limit_r <= avs_writedata[7:0];
      end
    end
  end

  assign online_en = !ctrl_r.monitor_disable;
  assign offline_en = online_en && !ctrl_r.online_only;
  assign report_on = ctrl_r.report_method != 4'h0;

  // Commands
  logic [2:0] func_code;
  logic rezero_go;
  logic exc_clr;
  logic diag_go;

  assign func_code = avs_writedata[drive_health_pkg::CMD_FUNC_LSB +: 3];
  assign rezero_go = wr_go && sel_cmd && avs_writedata[drive_health_pkg::CMD_REZERO];
  assign exc_clr = wr_go && sel_cmd && avs_writedata[drive_health_pkg::CMD_EXC_CLR];
  assign diag_go = wr_go && sel_cmd &&
    (func_code == drive_health_pkg::FUNC_SHORT || func_code == drive_health_pkg::FUNC_EXT);

  // Seconds enable
  logic [31:0] div_r;
  logic sec_tick;

  assign sec_tick = div_r == 32'(SEC_CYC - 1);
  always_ff @(posedge ref_clk) begin
    if (sys_rst || sec_tick) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
  end

  // Attribute monitors
  logic [N-1:0] pred;
  logic [N-1:0] pred_seen_r;
  logic [N-1:0] pred_new;
  logic [7:0] pred_fru;

  for (genvar i = 0; i < N; i++) begin : g_attr
    attr_rate_monitor #(
      .INTERVAL_LEN(drive_health_pkg::ATTR_INTV[i]),
      .ERR_THRESH(drive_health_pkg::ATTR_ERR[i]),
      .PRED_THRESH(drive_health_pkg::ATTR_PRED[i])
    ) u_mon (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .enable(online_en),
      .op_evt(attr_op[i]),
      .err_evt(attr_err[i]),
      .pred_fail(pred[i]),
      .history()
    );
  end

  assign pred_new = pred & ~pred_seen_r;
  always_comb begin
    pred_fru = 8'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (pred_new[i]) begin
        pred_fru = 8'(i + 1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pred_seen_r <= '0;
    end else begin
      pred_seen_r <= pred;
    end
  end

  // Hourly measurement timer, in seconds
  logic [11:0] meas_left_r;
  logic force_r;
  logic pass_done;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || rezero_go || pass_done) begin
      meas_left_r <= 12'(drive_health_pkg::HOUR_S);
    end else if (sec_tick && meas_left_r != 12'h000) begin
      meas_left_r <= meas_left_r - 12'h001;
    end
  end

  // Thermal sampling and limit check
  logic [9:0] temp_left_r;
  logic temp_req_r;
  logic [7:0] prim_r;
  logic [7:0] refr_r;
  logic temp_over_r;
  logic over_evt;
  logic temp_rep;

  assign over_evt = temp_valid && temp_primary > limit_r;
  assign temp_rep = over_evt && ctrl_r.temp_warning_enable && report_on;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      temp_left_r <= 10'(drive_health_pkg::TEMP_PERIOD_S);
      temp_req_r <= 1'b1;
    end else if (sec_tick && temp_left_r == 10'h001) begin
      temp_left_r <= 10'(drive_health_pkg::TEMP_PERIOD_S);
      temp_req_r <= 1'b1;
    end else begin
      if (sec_tick) begin
        temp_left_r <= temp_left_r - 10'h001;
      end
      if (temp_valid) begin
        temp_req_r <= 1'b0;
      end
    end
  end
  assign temp_sample = temp_req_r;

  // Log values come only from the sensor, never from the bus
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prim_r <= 8'h00;
      refr_r <= 8'h00;
      temp_over_r <= 1'b0;
    end else if (temp_valid) begin
      prim_r <= temp_primary;
      refr_r <= temp_reference;
      temp_over_r <= over_evt;
    end
  end

  // Offline pass and frame save sequencer
  off_state_t off_r;
  off_state_t off_nxt;
  logic frame_pend_r;
  logic from_meas_r;
  logic forced_r;
  logic [23:0] hold_cnt_r;
  logic pass_start;
  logic frame_start;
  logic abort_cond;
  logic hold_over;

  assign pass_start = off_r == OFF_IDLE && offline_en &&
    (force_r || (meas_left_r == 12'h000 && !host_busy));
  assign frame_start = off_r == OFF_IDLE && !pass_start && frame_pend_r && online_en && !host_busy;
  assign abort_cond = host_busy && !forced_r;
  assign hold_over = hold_cnt_r == 24'(DELAY_CYC - 1);
  assign pass_done = off_r == OFF_SAVE && save_done && from_meas_r;

  always_comb begin
    off_nxt = off_r;
    unique case (off_r)
      OFF_IDLE: begin
        if (pass_start) begin
          off_nxt = OFF_MEAS;
        end else if (frame_start) begin
          off_nxt = OFF_SAVE;
        end
      end
      OFF_MEAS: begin
        if (abort_cond) begin
          off_nxt = OFF_ABORT;
        end else if (meas_done) begin
          off_nxt = OFF_SAVE;
        end
      end
      OFF_SAVE: begin
        if (abort_cond) begin
          off_nxt = OFF_ABORT;
        end else if (save_done) begin
          off_nxt = OFF_IDLE;
        end
      end
      OFF_ABORT: begin
        if (meas_done || save_done || hold_over) begin
          off_nxt = OFF_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      off_r <= OFF_IDLE;
      force_r <= 1'b0;
      forced_r <= 1'b0;
      from_meas_r <= 1'b0;
      frame_pend_r <= 1'b0;
      hold_cnt_r <= 24'h00_0000;
    end else begin
      off_r <= off_nxt;
      // A new request wins over the clear of the same cycle
      force_r <= (rezero_go && offline_en) || (force_r && !pass_start);
      if (pass_start) begin
        forced_r <= force_r;
        from_meas_r <= 1'b1;
      end else if (frame_start) begin
        forced_r <= 1'b0;
        from_meas_r <= 1'b0;
      end
      frame_pend_r <= (over_evt && online_en) || (frame_pend_r && !frame_start);
      hold_cnt_r <= off_r == OFF_ABORT ? hold_cnt_r + 24'h00_0001 : 24'h00_0000;
    end
  end

  assign meas_req = off_r == OFF_MEAS;
  assign save_req = off_r == OFF_SAVE;
  assign meas_abort = off_r == OFF_ABORT;
  assign host_hold = off_r == OFF_ABORT;

  // Not-ready reporting
  logic not_ready_r;
  logic [7:0] nr_ascq_r;
  logic nr_now;

  assign nr_now = motor_spin_fail || motor_speed_fail || servo_lock_fail || config_read_fail;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      not_ready_r <= 1'b0;
      nr_ascq_r <= drive_health_pkg::ASCQ_NR_CAUSE;
    end else begin
      not_ready_r <= nr_now;
      nr_ascq_r <= config_read_fail ? drive_health_pkg::ASCQ_NR_MANUAL
                                    : drive_health_pkg::ASCQ_NR_CAUSE;
    end
  end
  assign not_ready = not_ready_r;

  // Self-test sequencer
  dst_state_t dst_r;
  logic [2:0] func_r;
  logic [3:0] result_r;
  logic [6:0] dst_left_r;
  logic start_r;
  logic stop_r;
  logic dst_accept;
  logic dst_fail;
  logic short_end;

  assign dst_accept = diag_go && dst_r == DST_IDLE && !not_ready_r;
  assign dst_fail = seek_err_final || track_err_final || read_err_final || write_err_final;
  assign short_end = func_r == drive_health_pkg::FUNC_SHORT && sec_tick && dst_left_r == 7'h00;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dst_r <= DST_IDLE;
      func_r <= 3'h0;
      result_r <= drive_health_pkg::RES_PASS;
      dst_left_r <= 7'h00;
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      start_r <= dst_accept;
      stop_r <= 1'b0;
      unique case (dst_r)
        DST_IDLE: begin
          if (dst_accept) begin
            dst_r <= DST_RUN;
            func_r <= func_code;
            result_r <= drive_health_pkg::RES_RUN;
            dst_left_r <= 7'(drive_health_pkg::SHORT_LIMIT_S - 1);
          end
        end
        DST_RUN: begin
          if (sec_tick && dst_left_r != 7'h00) begin
            dst_left_r <= dst_left_r - 7'h01;
          end
          if (dst_fail) begin
            dst_r <= DST_IDLE;
            result_r <= drive_health_pkg::RES_FAIL;
            stop_r <= 1'b1;
          end else if (dst_done || short_end) begin
            dst_r <= DST_IDLE;
            result_r <= drive_health_pkg::RES_PASS;
            stop_r <= short_end;
          end
        end
      endcase
    end
  end

  assign dst_start = start_r;
  assign dst_stop = stop_r;
  assign dst_scan_all = dst_r == DST_RUN && func_r == drive_health_pkg::FUNC_EXT;
  assign retry_force = dst_r == DST_RUN;

  // Informational exception, sticky until cleared
  logic exc_valid_r;
  drive_health_pkg::sense_t exc_r;
  logic pred_rep;

  assign pred_rep = (|pred_new) && report_on;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      exc_valid_r <= 1'b0;
      exc_r <= '0;
    end else if (temp_rep) begin
      exc_valid_r <= 1'b1;
      exc_r <= {drive_health_pkg::FRU_TEMP, drive_health_pkg::KEY_RECOV,
                drive_health_pkg::ASC_TEMP, drive_health_pkg::ASCQ_TEMP};
    end else if (pred_rep) begin
      exc_valid_r <= 1'b1;
      exc_r <= {pred_fru, drive_health_pkg::KEY_RECOV, drive_health_pkg::ASC_PRED, 8'h00};
    end else if (exc_clr) begin
      exc_valid_r <= 1'b0;
    end
  end
  assign exc_pending = exc_valid_r;
  assign exc_sense = exc_r;

  // Read data selection
  logic [31:0] stat_word;
  assign stat_word = {drive_health_pkg::KEY_NREADY & {8{not_ready_r}},
                      drive_health_pkg::ASC_NREADY & {8{not_ready_r}},
                      nr_ascq_r & {8{not_ready_r}}, 3'h0, exc_valid_r,
                      |pred, temp_over_r, off_r != OFF_IDLE, not_ready_r};
  assign rdata_mux = sel_ctrl ? {25'h000_0000, ctrl_r} :
                     sel_limit ? {24'h00_0000, limit_r} :
                     sel_time ? {20'h0_0000, meas_left_r} :
                     sel_temp ? {16'h0000, refr_r, prim_r} :
                     sel_exc ? exc_r :
                     sel_diag ? {23'h00_0000, dst_r == DST_RUN, 1'b0, func_r, result_r} :
                     sel_stat ? stat_word : 32'h0000_0000;
endmodule : drive_health_monitor

// *** rtl/drive_health_pkg.sv ***
// Constants, register map and carrier types of the drive health monitor.
// Assumes a 20 MHz ref_clk and byte addresses on the register bus.
package drive_health_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SEC_S = 1;
  localparam int unsigned SEC_CYC = CLK_HZ * SEC_S;
  localparam int unsigned HOUR_S = 3600;
  localparam int unsigned TEMP_PERIOD_S = 600;
  localparam int unsigned SHORT_LIMIT_S = 120;
  localparam int unsigned MAX_DELAY_MS = 75;
  localparam int unsigned DELAY_CYC = CLK_HZ / 1000 * MAX_DELAY_MS;

  // Per-attribute build-time constants
  localparam int unsigned ATTR_N = 2;
  localparam int unsigned ATTR_INTV [ATTR_N] = '{1000, 4000};
  localparam int unsigned ATTR_ERR [ATTR_N] = '{20, 8};
  localparam int unsigned ATTR_PRED [ATTR_N] = '{8, 4};

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_LIMIT = 8'h08;
  localparam logic [7:0] OFF_TIME = 8'h0C;
  localparam logic [7:0] OFF_TEMP = 8'h10;
  localparam logic [7:0] OFF_EXC = 8'h14;
  localparam logic [7:0] OFF_DIAG = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;

  // Command register fields
  localparam int unsigned CMD_REZERO = 0;
  localparam int unsigned CMD_EXC_CLR = 1;
  localparam int unsigned CMD_FUNC_LSB = 5;
  localparam logic [2:0] FUNC_SHORT = 3'h1;
  localparam logic [2:0] FUNC_EXT = 3'h2;

  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h0C;
  localparam logic [7:0] LIMIT_RST = 8'h3C;

  // Self-test result codes
  localparam logic [3:0] RES_PASS = 4'h0;
  localparam logic [3:0] RES_FAIL = 4'h7;
  localparam logic [3:0] RES_RUN = 4'hF;

  // Sense bytes
  localparam logic [7:0] KEY_RECOV = 8'h01;
  localparam logic [7:0] KEY_NREADY = 8'h02;
  localparam logic [7:0] ASC_PRED = 8'h5D;
  localparam logic [7:0] ASC_TEMP = 8'h0B;
  localparam logic [7:0] ASCQ_TEMP = 8'h01;
  localparam logic [7:0] ASC_NREADY = 8'h04;
  localparam logic [7:0] ASCQ_NR_CAUSE = 8'h00;
  localparam logic [7:0] ASCQ_NR_MANUAL = 8'h03;
  localparam logic [7:0] FRU_TEMP = 8'h00;

  // Control register layout: bit 6 down to bit 0
  typedef struct packed {
    logic [3:0] report_method;
    logic temp_warning_enable;
    logic online_only;
    logic monitor_disable;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] fru;
    logic [7:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sense_t;
endpackage : drive_health_pkg

// *** test/drive_health_monitor_asserts.sv ***
// Port checker for the drive health monitor.
// Assumes one clock domain; bound to every monitor instance.
`timescale 1ns/1ps
module drive_health_monitor_asserts #(
  parameter int unsigned DELAY_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic meas_req,
  input wire logic meas_abort,
  input wire logic meas_done,
  input wire logic save_req,
  input wire logic temp_sample,
  input wire logic temp_valid,
  input wire logic motor_spin_fail,
  input wire logic motor_speed_fail,
  input wire logic servo_lock_fail,
  input wire logic config_read_fail,
  input wire logic not_ready,
  input wire logic dst_scan_all,
  input wire logic retry_force,
  input wire logic seek_err_final,
  input wire logic track_err_final,
  input wire logic read_err_final,
  input wire logic write_err_final,
  input wire logic dst_stop,
  input wire logic exc_pending,
  input wire drive_health_pkg::sense_t exc_sense
);
  logic [31:0] ab_n;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_meas_ok;
    meas_req && meas_done && !meas_abort;
  endsequence
  // Abort may last far beyond a repetition count, so it is counted
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !meas_abort) ab_n <= 32'h0000_0000;
    else ab_n <= ab_n + 32'h0000_0001;
  end
  AST_BUS_WAIT: assert property ($rose(avs_read) |-> s_one_wait)
    else $error("read not answered after one wait cycle");
  AST_ABORT_LEN: assert property (ab_n <= DELAY_CYC + 1)
    else $error("host held by monitoring too long");
  AST_NOT_READY: assert property (!$past(sys_rst) |->
    not_ready == $past(motor_spin_fail | motor_speed_fail | servo_lock_fail | config_read_fail))
    else $error("not ready does not follow faults");
  AST_MEAS_SAVE: assert property (s_meas_ok |=> save_req)
    else $error("measurement not followed by save");
  AST_TEMP_REQ: assert property (temp_sample && temp_valid |=> !temp_sample)
    else $error("sample request outlives its answer");
  AST_EXC_TEMP: assert property (exc_pending && exc_sense.asc == 8'h0B |-> exc_sense == 32'h0001_0B01)
    else $error("bad temperature sense");
  AST_EXC_PRED: assert property (exc_pending && exc_sense.asc == 8'h5D |->
    exc_sense inside {32'h0101_5D00, 32'h0201_5D00})
    else $error("bad predictive sense");
  AST_FAIL_STOP: assert property (retry_force && (seek_err_final | track_err_final |
    read_err_final | write_err_final) |=> dst_stop)
    else $error("unrecovered error did not stop test");
  AST_EXT_RETRY: assert property (dst_scan_all |-> retry_force)
    else $error("full scan without retries");
endmodule : drive_health_monitor_asserts

bind drive_health_monitor drive_health_monitor_asserts #(.DELAY_CYC(DELAY_CYC)) drive_health_monitor_asserts_inst (
  .ref_clk, .sys_rst, .avs_read, .avs_waitrequest, .meas_req, .meas_abort, .meas_done, .save_req,
  .temp_sample, .temp_valid, .motor_spin_fail, .motor_speed_fail, .servo_lock_fail, .config_read_fail,
  .not_ready, .dst_scan_all, .retry_force, .seek_err_final, .track_err_final, .read_err_final,
  .write_err_final, .dst_stop, .exc_pending, .exc_sense);

// *** test/drive_health_monitor_tb.sv ***
// Self-checking bench for the drive health monitor.
// Short second and abort counts keep the run near 38k cycles.
`timescale 1ns/1ps
module drive_health_monitor_tb;
  localparam int unsigned SEC = 4;
  localparam int unsigned DLY = 10;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [1:0] attr_op = 2'b00;
  logic [1:0] attr_err = 2'b00;
  logic host_busy = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [3:0] efin = 4'h0;
  logic [7:0] lat = 8'h04;
  logic dst_hang = 1'b0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest, host_hold, meas_req, meas_abort, meas_done, save_req, save_done;
  logic temp_sample, temp_valid, not_ready, dst_start, dst_stop, dst_scan_all, retry_force, dst_done;
  logic exc_pending;
  logic [7:0] temp_primary;
  logic [7:0] temp_reference;
  drive_health_pkg::sense_t exc_sense;
  int n_fail = 0;
  int num_checks = 0;
  int cyc_n = 0;
  bit bad [10] = '{1, 1, 1, 1, 1, 1, 1, 0, 1, 1};
  always #25 ref_clk = ~ref_clk;
  drive_health_monitor #(.SEC_CYC(SEC), .DELAY_CYC(DLY)) drive_health_monitor_inst (
    .ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .attr_op, .attr_err, .host_busy, .host_hold, .meas_req, .meas_abort,
    .meas_done, .save_req, .save_done, .temp_sample, .temp_valid, .temp_primary, .temp_reference,
    .motor_spin_fail(flt[0]), .motor_speed_fail(flt[1]), .servo_lock_fail(flt[2]),
    .config_read_fail(flt[3]), .not_ready, .dst_start, .dst_stop, .dst_scan_all, .retry_force,
    .dst_done, .seek_err_final(efin[0]), .track_err_final(efin[1]), .read_err_final(efin[2]),
    .write_err_final(efin[3]), .exc_pending, .exc_sense);
  media_engine_model media_engine_model_inst (
    .ref_clk, .sys_rst, .lat, .dst_hang, .meas_req, .meas_abort, .meas_done, .save_req,
    .save_done, .temp_sample, .temp_valid, .temp_primary, .temp_reference, .dst_start,
    .dst_stop, .dst_done);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic pls(input bit e);
    // Errors go to attribute 0 only; attribute 1 sees operations alone
    if (e) attr_err <= 2'b01;
    else attr_op <= 2'b11;
    @(posedge ref_clk);
    attr_err <= 2'b00;
    attr_op <= 2'b00;
    @(posedge ref_clk);
  endtask : pls
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  always @(posedge ref_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 90000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    bus(0, 8'h00, 32'h0000_0000);
    chk("ctrl", rd, 32'(drive_health_pkg::CTRL_RST));
    bus(1, 8'h10, 32'hFFFF_FFFF);
    bus(0, 8'h10, 32'h0000_0000);
    chk("temp_log", rd, 32'h0000_2030);
    bus(1, 8'h04, 32'h0000_0001);
    while (save_done !== 1'b1) @(posedge ref_clk);
    bus(0, 8'h0C, 32'h0000_0000);
    chk("time", rd, 32'(drive_health_pkg::HOUR_S));
    cyc(20);
    // Disabled and online-only modes both refuse a forced pass
    for (int m = 1; m < 3; m++) begin
      bus(1, 8'h00, 32'h0000_000C | 32'(m));
      bus(1, 8'h04, 32'h0000_0001);
      cyc(4);
      chk("mode_meas", 32'(meas_req), 32'h0000_0000);
    end
    bus(1, 8'h00, 32'h0000_000C);
    lat <= 8'h28;
    while (meas_req !== 1'b1) @(posedge ref_clk);
    host_busy <= 1'b1;
    cyc(2);
    chk("abort", 32'({meas_abort, host_hold}), 32'h0000_0003);
    cyc(DLY + 2);
    chk("abort_end", 32'(meas_abort), 32'h0000_0000);
    host_busy <= 1'b0;
    lat <= 8'h04;
    bus(1, 8'h08, 32'h0000_0020);
    while (exc_pending !== 1'b1) @(posedge ref_clk);
    chk("temp_sense", exc_sense, 32'h0001_0B01);
    bus(1, 8'h08, 32'(drive_health_pkg::LIMIT_RST));
    bus(1, 8'h04, 32'h0000_0002);
    cyc(2);
    chk("exc_clr", 32'(exc_pending), 32'h0000_0000);
    // Twenty errors in an interval is still acceptable
    for (int k = 0; k < 10; k++) begin
      if (k == 9) chk("pred_early", 32'(exc_pending), 32'h0000_0000);
      repeat (bad[k] ? 21 : 20) pls(1'b1);
      // A bad interval ends at once, so 999 ops leave the next one open
      repeat (bad[k] ? 999 : 1000) pls(1'b0);
    end
    cyc(4);
    chk("pred_sense", exc_sense, 32'h0101_5D00);
    for (int f = 0; f < 4; f++) begin
      flt <= 4'h1 << f;
      cyc(3);
      chk("not_ready", 32'(not_ready), 32'h0000_0001);
    end
    bus(0, 8'h1C, 32'h0000_0000);
    chk("nr_sense", rd & 32'hFFFF_FF01, 32'h0204_0301);
    bus(1, 8'h04, 32'h0000_0020);
    cyc(3);
    chk("refused", 32'(retry_force), 32'h0000_0000);
    flt <= 4'h0;
    cyc(3);
    bus(1, 8'h04, 32'h0000_0040);
    while (dst_start !== 1'b1) @(posedge ref_clk);
    cyc(1);
    chk("ext_scan", 32'(dst_scan_all), 32'h0000_0001);
    while (dst_done !== 1'b1) @(posedge ref_clk);
    cyc(2);
    bus(0, 8'h18, 32'h0000_0000);
    chk("ext_res", rd & 32'h0000_017F, 32'h0000_0020);
    dst_hang <= 1'b1;
    bus(1, 8'h04, 32'h0000_0020);
    while (dst_start !== 1'b1) @(posedge ref_clk);
    cyc(2);
    chk("short_run", 32'({dst_scan_all, retry_force}), 32'h0000_0001);
    efin <= 4'h4;
    @(posedge ref_clk);
    efin <= 4'h0;
    cyc(3);
    bus(0, 8'h18, 32'h0000_0000);
    chk("short_res", rd & 32'h0000_017F, 32'h0000_0017);
    bus(1, 8'h04, 32'h0000_0020);
    while (dst_stop !== 1'b1) @(posedge ref_clk);
    bus(0, 8'h18, 32'h0000_0000);
    chk("short_lim", rd & 32'h0000_017F, 32'h0000_0010);
    dst_hang <= 1'b0;
    test_done();
  end
endmodule : drive_health_monitor_tb

// *** test/media_engine_model.sv ***
// Behavioural media, sensor and self-test engines facing the monitor.
// Each request is answered after lat + 1 cycles; dst_hang keeps a test running.
`timescale 1ns/1ps
module media_engine_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] lat,
  input wire logic dst_hang,
  input wire logic meas_req,
  input wire logic meas_abort,
  output logic meas_done,
  input wire logic save_req,
  output logic save_done,
  input wire logic temp_sample,
  output logic temp_valid,
  output logic [7:0] temp_primary,
  output logic [7:0] temp_reference,
  input wire logic dst_start,
  input wire logic dst_stop,
  output logic dst_done
);
  logic [3:0] rq;
  logic [3:0] ak;
  logic [7:0] c [4];
  logic run_r;
  assign rq = {run_r & !dst_hang, temp_sample, save_req, meas_req | meas_abort};
  assign {dst_done, temp_valid, save_done, meas_done} = ak;
  // Sensor bus shows inverted data outside the strobe
  assign temp_primary = temp_valid ? 8'h30 : 8'hCF;
  assign temp_reference = temp_valid ? 8'h20 : 8'hDF;
  always_ff @(posedge ref_clk) begin
    run_r <= !sys_rst && (dst_start || (run_r && !dst_stop && !ak[3]));
    for (int i = 0; i < 4; i++) begin
      if (sys_rst || !rq[i] || ak[i]) begin
        c[i] <= 8'h00;
        ak[i] <= 1'b0;
      end else begin
        c[i] <= c[i] + 8'h01;
        ak[i] <= (c[i] == lat);
      end
    end
  end
endmodule : media_engine_model
